// File: tcmr_regs.sv
// mode select and lamp effect setup registers behind the serial host port
`include "tcmr_consts.svh"

// Contract
// - registers hold documented access and power-on values
// - reserved offsets promise nothing; read as zero
// - mode field bits 2:0 at offset 00h
// - mode codes 000..100 valid, 101..111 invalid
// - bit 7 limits effects to last button
// - bit 1 power-on enable, bit 0 ordering
// - bit 2 enables button touch effects
// - field selects standby lamp brightness
// - bit enables lamp hold after release
// - bit enables analog voltage output
// - brightness codes map 0, 20, 30, 50 percent
// - ordering: together, or outputs 0 to 9
// - touch settings ignored while touch effects off
module tcmr_regs
  import tcmr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `TCMR_DEV_ADDR // arbitrary slave address
) (
  input  wire logic       clk_i,            // 250 MHz system clock
  input  wire logic       rst_i,            // synchronous reset, active high
  input  wire logic       scl_i,            // serial clock pin
  input  wire logic       sda_i,            // serial data pin level
  output logic            sda_o,            // serial data drive value
  output logic            sda_oe_o,         // high while pulling data low
  output logic      [2:0] mode_o,           // operating mode
  output logic            last_btn_only_o,  // effects on last button only
  output logic            analog_out_en_o,  // analog voltage output enable
  output logic      [1:0] sby_bright_o,     // standby brightness code
  output logic      [5:0] sby_pct_o,        // standby brightness percent
  output logic            hold_on_en_o,     // lamp hold after release enable
  output logic            touch_fx_en_o,    // touch effect settings in use
  output logic            pwron_fx_en_o,    // power-on effects enable
  output logic            pwron_all_o,      // power-on on all outputs at once
  output logic            pwron_serial_o    // power-on outputs 0 through 9
);

  // ----------------------------------------------------------------------
  // storage and protocol state
  // ----------------------------------------------------------------------
  tcmr_state_t state_q, state_d;
  tcmr_state_t after_ack_q, after_ack_d;
  logic [2:0] mode_q;
  logic [7:0] lamp_q;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic       oe_q, oe_d;
  logic [5:0] pct_q;
  logic       pwron_all_q, pwron_ser_q;

  logic       sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  logic [2:0] mode_next;
  logic [5:0] pct_next;

  // ----------------------------------------------------------------------
  // pins and field decode
  // ----------------------------------------------------------------------
  tcmr_pin_sync tcmr_pin_sync_inst (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_s_o    (sda_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (bus_start),
    .stop_o     (bus_stop)
  );

  tcmr_field_decode tcmr_field_decode_inst (
    .mode_cur_i  (mode_q),
    .wdata_i     (shift_q),
    .sby_code_i  (lamp_q[`TCMR_LAMP_SBY_MSB:`TCMR_LAMP_SBY_LSB]),
    .mode_next_o (mode_next),
    .sby_pct_o   (pct_next)
  );

  // ----------------------------------------------------------------------
  // decode of byte ends and register access
  // ----------------------------------------------------------------------
  wire       byte_done = scl_fall & (bitcnt_q == `TCMR_BITS_PER_BYTE);
  wire       addr_hit  = (shift_q[7:1] == DEV_ADDR);
  wire       reg_wr    = (state_q == TCMR_ST_WDAT) & byte_done;
  wire       wr_mode   = reg_wr & (ptr_q == `TCMR_OFS_MODE);
  wire       wr_lamp   = reg_wr & (ptr_q == `TCMR_OFS_LAMP);
  // upper mode bits always read zero
  wire [7:0] rd_mode   = {5'h00, mode_q};
  // unmapped and reserved offsets give a fixed zero byte
  wire [7:0] rd_data   = (ptr_q == `TCMR_OFS_MODE) ? rd_mode :
                         (ptr_q == `TCMR_OFS_LAMP) ? lamp_q :
                         `TCMR_RST_UNMAPPED;
  wire       rack_ok   = (state_q == TCMR_ST_RACK) & scl_rise & ~sda_s;

  // ----------------------------------------------------------------------
  // serial slave sequencing; no clock stretching, so every step
  // fits inside one bus clock phase
  // ----------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    after_ack_d = after_ack_q;
    ptr_d       = ptr_q;
    shift_d     = shift_q;
    bitcnt_d    = bitcnt_q;
    oe_d        = oe_q;
    case (state_q)
      TCMR_ST_IDLE: begin
        oe_d = 1'b0;
      end
      TCMR_ST_ADDR, TCMR_ST_PTR, TCMR_ST_WDAT: begin
        if (scl_rise) begin
          shift_d  = {shift_q[6:0], sda_s};
          bitcnt_d = bitcnt_q + 4'h1;
        end else if (byte_done) begin
          bitcnt_d = 4'h0;
          state_d  = TCMR_ST_ACK;
          oe_d     = 1'b1;
          if (state_q == TCMR_ST_ADDR) begin
            after_ack_d = shift_q[0] ? TCMR_ST_RDAT : TCMR_ST_PTR;
            if (!addr_hit) begin
              state_d = TCMR_ST_IDLE;
              oe_d    = 1'b0;
            end
          end else if (state_q == TCMR_ST_PTR) begin
            ptr_d       = shift_q;
            after_ack_d = TCMR_ST_WDAT;
          end else begin
            ptr_d       = ptr_q + 8'h01;
            after_ack_d = TCMR_ST_WDAT;
          end
        end
      end
      TCMR_ST_ACK: begin
        if (scl_fall) begin
          state_d = after_ack_q;
          oe_d    = 1'b0;
          if (after_ack_q == TCMR_ST_RDAT) begin
            shift_d = rd_data;
            oe_d    = ~rd_data[7];
          end
        end
      end
      TCMR_ST_RDAT: begin
        if (scl_fall) begin
          if (bitcnt_q == 4'h7) begin
            bitcnt_d = 4'h0;
            oe_d     = 1'b0;
            state_d  = TCMR_ST_RACK;
          end else begin
            bitcnt_d = bitcnt_q + 4'h1;
            shift_d  = {shift_q[6:0], 1'b0};
            oe_d     = ~shift_q[6];
          end
        end
      end
      TCMR_ST_RACK: begin
        // a host nack ends the read; an ack moves to the next byte
        if (rack_ok) begin
          ptr_d = ptr_q + 8'h01;
        end else if (scl_rise) begin
          state_d = TCMR_ST_IDLE;
        end else if (scl_fall) begin
          state_d = TCMR_ST_RDAT;
          shift_d = rd_data;
          oe_d    = ~rd_data[7];
        end
      end
      default: begin
        state_d = TCMR_ST_IDLE;
        oe_d    = 1'b0;
      end
    endcase
    // bus conditions override any byte in progress
    if (bus_start) begin
      state_d  = TCMR_ST_ADDR;
      bitcnt_d = 4'h0;
      oe_d     = 1'b0;
    end else if (bus_stop) begin
      state_d = TCMR_ST_IDLE;
      oe_d    = 1'b0;
    end
  end

  // protocol registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= TCMR_ST_IDLE;
      after_ack_q <= TCMR_ST_IDLE;
      ptr_q       <= 8'h00;
      shift_q     <= 8'h00;
      bitcnt_q    <= 4'h0;
      oe_q        <= 1'b0;
    end else begin
      state_q     <= state_d;
      after_ack_q <= after_ack_d;
      ptr_q       <= ptr_d;
      shift_q     <= shift_d;
      bitcnt_q    <= bitcnt_d;
      oe_q        <= oe_d;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers; power-on values come from reset
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `TCMR_RST_MODE;
      lamp_q <= `TCMR_RST_LAMP;
      pct_q  <= `TCMR_PCT_00;
      pwron_all_q <= 1'b0;
      pwron_ser_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_q <= mode_next;
      end
      if (wr_lamp) begin
        lamp_q <= shift_q;
        pwron_all_q <= shift_q[`TCMR_LAMP_PWRON_FX] & ~shift_q[`TCMR_LAMP_PWRON_SEQ];
        pwron_ser_q <= shift_q[`TCMR_LAMP_PWRON_FX] & shift_q[`TCMR_LAMP_PWRON_SEQ];
      end
      pct_q <= pct_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, each straight from a flip-flop except the tied-low sda_o
  // ----------------------------------------------------------------------
  assign sda_o           = 1'b0; // open drain: only ever pulls low
  assign sda_oe_o        = oe_q;
  assign mode_o          = mode_q;
  assign last_btn_only_o = lamp_q[`TCMR_LAMP_LAST_BTN];
  assign analog_out_en_o = lamp_q[`TCMR_LAMP_ANALOG];
  assign sby_bright_o    = lamp_q[`TCMR_LAMP_SBY_MSB:`TCMR_LAMP_SBY_LSB];
  assign sby_pct_o       = pct_q;
  assign hold_on_en_o    = lamp_q[`TCMR_LAMP_HOLD_ON];
  // touch effect settings are only honoured while this bit is set
  assign touch_fx_en_o   = lamp_q[`TCMR_LAMP_TOUCH_FX];
  assign pwron_fx_en_o   = lamp_q[`TCMR_LAMP_PWRON_FX];
  // decoded at the write so both come from flops and never overlap
  assign pwron_all_o     = pwron_all_q;
  assign pwron_serial_o  = pwron_ser_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_reset_values: assert property (@(posedge clk_i)
    rst_i |=> (mode_q == `TCMR_RST_MODE) && (lamp_q == `TCMR_RST_LAMP) && !sda_oe_o)
    else $error("register not at power-on value after reset");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ptr_q > `TCMR_OFS_LAMP) |-> (rd_data == 8'h00))
    else $error("unmapped offset did not read zero");

  a_mode_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    tcmr_mode_ok(mode_q))
    else $error("mode holds an invalid code");

  a_mode_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode && tcmr_mode_ok(shift_q[2:0]) |=> (mode_q == $past(shift_q[2:0])))
    else $error("valid mode write not taken");

  a_mode_keep_bad: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode && !tcmr_mode_ok(shift_q[2:0]) |=> $stable(mode_q))
    else $error("invalid mode write changed the mode");

  a_mode_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ptr_q == `TCMR_OFS_MODE) |-> (rd_data[7:3] == 5'h00))
    else $error("mode upper bits read nonzero");

  a_lamp_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lamp |=> (lamp_q == $past(shift_q)) ##1 (touch_fx_en_o == lamp_q[2]))
    else $error("lamp setup write not stored");

  a_lamp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_lamp |=> $stable(lamp_q))
    else $error("lamp setup changed without a write");

  a_bright_pct: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (sby_pct_o == (($past(sby_bright_o) == 2'h0) ? 6'h00 :
                       ($past(sby_bright_o) == 2'h1) ? 6'h14 :
                       ($past(sby_bright_o) == 2'h2) ? 6'h1e : 6'h32)))
    else $error("standby percent does not match code");

  a_pwron_order: assert property (@(posedge clk_i) disable iff (rst_i)
    !(pwron_all_o && pwron_serial_o) && ((pwron_all_o || pwron_serial_o) == pwron_fx_en_o))
    else $error("power-on ordering outputs inconsistent");

  a_pwron_track: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwron_serial_o == (pwron_fx_en_o && lamp_q[`TCMR_LAMP_PWRON_SEQ])))
    else $error("power-on sequence output does not follow its bit");

  a_ack_slot: assert property (@(posedge clk_i) disable iff (rst_i || bus_start || bus_stop)
    (state_q == TCMR_ST_ACK) |-> sda_oe_o)
    else $error("acknowledge slot not driven");

endmodule // tcmr_regs

// File: tcmr_consts.svh
// register offsets, field positions, reset values, brightness table and serial interface constants
`ifndef TCMR_CONSTS_SVH
`define TCMR_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (printed offsets on the serial host interface)
// ----------------------------------------------------------------------
`define TCMR_OFS_MODE       8'h00
`define TCMR_OFS_LAMP       8'h01

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TCMR_MODE_MSB       2
`define TCMR_LAMP_LAST_BTN  7
`define TCMR_LAMP_ANALOG    6
`define TCMR_LAMP_SBY_MSB   5
`define TCMR_LAMP_SBY_LSB   4
`define TCMR_LAMP_HOLD_ON   3
`define TCMR_LAMP_TOUCH_FX  2
`define TCMR_LAMP_PWRON_FX  1
`define TCMR_LAMP_PWRON_SEQ 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TCMR_RST_MODE       3'h0
`define TCMR_RST_LAMP       8'h00
`define TCMR_RST_UNMAPPED   8'h00

// ----------------------------------------------------------------------
// standby brightness in percent
// ----------------------------------------------------------------------
`define TCMR_PCT_00         6'h00
`define TCMR_PCT_01         6'h14
`define TCMR_PCT_10         6'h1e
`define TCMR_PCT_11         6'h32

// ----------------------------------------------------------------------
// serial interface
// ----------------------------------------------------------------------
`define TCMR_BITS_PER_BYTE  4'h8
`define TCMR_DEV_ADDR       7'h37

`endif

// File: tcmr_pkg.sv
// types shared by the touch controller mode and lamp register bank
package tcmr_pkg;

  // ----------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TCMR_MODE_NORMAL = 3'h0,
    TCMR_MODE_LAMP   = 3'h1,
    TCMR_MODE_DEVCFG = 3'h2,
    TCMR_MODE_PLTEST = 3'h3,
    TCMR_MODE_DEBUG  = 3'h4
  } tcmr_mode_t;

  // ----------------------------------------------------------------------
  // serial slave states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    TCMR_ST_IDLE = 7'h01,
    TCMR_ST_ADDR = 7'h02,
    TCMR_ST_PTR  = 7'h04,
    TCMR_ST_WDAT = 7'h08,
    TCMR_ST_ACK  = 7'h10,
    TCMR_ST_RDAT = 7'h20,
    TCMR_ST_RACK = 7'h40
  } tcmr_state_t;

  // mode codes above debug data are not valid
  function automatic logic tcmr_mode_ok(input logic [2:0] code);
    tcmr_mode_ok = (code <= TCMR_MODE_DEBUG);
  endfunction

endpackage

// File: tcmr_pin_sync.sv
// two-flop synchroniser and bus event detector for the serial pins
module tcmr_pin_sync (
  input  wire logic clk_i,     // system clock
  input  wire logic rst_i,     // synchronous reset, active high
  input  wire logic scl_i,     // serial clock pin
  input  wire logic sda_i,     // serial data pin
  output logic      sda_s_o,   // synchronised data level
  output logic      scl_rise_o, // clock rising edge pulse
  output logic      scl_fall_o, // clock falling edge pulse
  output logic      start_o,   // start or repeated start pulse
  output logic      stop_o     // stop condition pulse
);

  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  // ----------------------------------------------------------------------
  // synchronisers; idle bus reads high
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, scl_i};
      {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_i};
    end
  end

  // edge logic only reads the second and third stages
  assign sda_s_o    = sda_s_q;
  assign scl_rise_o = scl_s_q & ~scl_p_q;
  assign scl_fall_o = ~scl_s_q & scl_p_q;
  assign start_o    = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_o     = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

endmodule // tcmr_pin_sync

// File: tcmr_field_decode.sv
// mode write filter and standby brightness decoder
`include "tcmr_consts.svh"

module tcmr_field_decode
  import tcmr_pkg::*;
(
  input  wire logic [2:0] mode_cur_i,  // mode held now
  input  wire logic [7:0] wdata_i,     // byte written by the host
  input  wire logic [1:0] sby_code_i,  // standby brightness code
  output logic      [2:0] mode_next_o, // mode after a write
  output logic      [5:0] sby_pct_o    // brightness in percent
);

  // an invalid code leaves the mode as it was; upper bits are dropped
  assign mode_next_o = tcmr_mode_ok(wdata_i[`TCMR_MODE_MSB:0]) ?
                       wdata_i[`TCMR_MODE_MSB:0] : mode_cur_i;

  // standby brightness table
  assign sby_pct_o = (sby_code_i == 2'h0) ? `TCMR_PCT_00 :
                     (sby_code_i == 2'h1) ? `TCMR_PCT_01 :
                     (sby_code_i == 2'h2) ? `TCMR_PCT_10 : `TCMR_PCT_11;

endmodule // tcmr_field_decode

// File: tcmr_host_model.sv
// host processor model that drives the serial host port by bit-banging
module tcmr_host_model (
  input  wire logic clk_i,     // system clock, paces every bit
  input  wire logic sda_i,     // resolved data wire level
  output logic      scl_o,     // serial clock, driven by the host only
  output logic      sda_low_o  // high while the host pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;

  int         q_cycles = 6; // quarter bit time; raised to play a slow host
  logic       all_acked;    // every byte the host sent in the last frame was acked
  logic [7:0] rd_byte;      // byte taken by the last read

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
    all_acked = 1'b0;
    rd_byte   = 8'h00;
  end

  task automatic wait_q();
    repeat (q_cycles) @(posedge clk_i);
  endtask

  // data moves only while the clock is low, so no false start or stop
  task automatic put_bit(input logic b, output logic seen);
    sda_low_o <= ~b;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    wait_q();
    seen = sda_i;
    scl_o <= 1'b0;
    wait_q();
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    @(posedge clk_i);
    sda_low_o <= 1'b0;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    sda_low_o <= 1'b1;
    wait_q();
    scl_o <= 1'b0;
    wait_q();
  endtask

  // stop: data rises while the clock is high, the wire is then released
  task automatic stop_cond();
    sda_low_o <= 1'b1;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    sda_low_o <= 1'b0;
    wait_q();
  endtask

  // a byte msb first, then the ninth clock with the wire released
  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    all_acked = all_acked & ~s;
  endtask

  // host gives no ack after the byte, which ends the read
  task automatic recv_byte();
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      rd_byte[i] = s;
    end
    put_bit(1'b1, s);
  endtask

  // write frame; mode codes sent are only those the bench asks for
  task automatic reg_write(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d, input int n);
    all_acked = 1'b1;
    start_cond();
    send_byte({dev, 1'b0});
    send_byte(ofs);
    send_byte(d[7:0]);
    if (n > 1) begin
      send_byte(d[15:8]);
    end
    stop_cond();
  endtask

  // read frame: pointer write, repeated start, one byte
  task automatic reg_read(input logic [6:0] dev, input logic [7:0] ofs);
    all_acked = 1'b1;
    start_cond();
    send_byte({dev, 1'b0});
    send_byte(ofs);
    start_cond();
    send_byte({dev, 1'b1});
    recv_byte();
    stop_cond();
  endtask
endmodule // tcmr_host_model

// File: tcmr_regs_bench.sv
// self-checking bench for the mode and lamp setup register bank
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp); \
    end \
  end

module tcmr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] DEV = 7'h37; // arbitrary slave address
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       scl, host_low, sda_drv, sda_oe;
  logic [2:0] mode;
  logic [1:0] sby;
  logic [5:0] pct;
  logic       last_btn, analog_en, hold_on, touch_fx, pwron_fx, pwron_all, pwron_ser;
  int         bad_count = 0;
  int         checks_done = 0;
  // open-drain data wire with a pull-up
  wire logic  sda_w = !(host_low || (sda_oe && !sda_drv));

  always #2 clk = ~clk;

  tcmr_host_model tcmr_host_model_inst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

  tcmr_regs #(.DEV_ADDR(DEV)) tcmr_regs_inst (
    .clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_drv), .sda_oe_o(sda_oe),
    .mode_o(mode), .last_btn_only_o(last_btn), .analog_out_en_o(analog_en), .sby_bright_o(sby),
    .sby_pct_o(pct), .hold_on_en_o(hold_on), .touch_fx_en_o(touch_fx), .pwron_fx_en_o(pwron_fx),
    .pwron_all_o(pwron_all), .pwron_serial_o(pwron_ser));

  // ----------------------------------------------------------------------
  // access and check tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] ofs, input logic [15:0] d, input int n);
    tcmr_host_model_inst.reg_write(DEV, ofs, d, n);
    `CHK(tcmr_host_model_inst.all_acked, 1'b1)
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    tcmr_host_model_inst.reg_read(DEV, ofs);
    `CHK(tcmr_host_model_inst.rd_byte, exp)
  endtask

  // outputs are looked at off the clock edge so no update races the check
  task automatic check_lamp(input logic [7:0] b);
    logic [5:0] pct_tab [4];
    pct_tab = '{6'h00, 6'h14, 6'h1e, 6'h32};
    @(negedge clk);
    `CHK(last_btn, b[7])
    `CHK(analog_en, b[6])
    `CHK(sby, b[5:4])
    `CHK(pct, pct_tab[b[5:4]])
    `CHK(hold_on, b[3])
    `CHK(touch_fx, b[2])
    `CHK(pwron_fx, b[1])
    `CHK(pwron_all, b[1] & ~b[0])
    `CHK(pwron_ser, b[1] & b[0])
  endtask

  task automatic check_mode(input logic [2:0] m);
    @(negedge clk);
    `CHK(mode, m)
  endtask

  task automatic done(input string n);
    $display("test %s finished, %0d mismatches so far", n, bad_count);
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] pat [12];
    pat = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h03, 8'hff, 8'ha5, 8'h00};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check_mode(3'h0);
    check_lamp(8'h00);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    done("power_on");
    // every valid code, with the unused upper bits written as ones
    for (int m = 0; m <= 4; m++) begin
      wr(8'h00, {8'h00, 5'h1f, m[2:0]}, 1);
      check_mode(m[2:0]);
      rd(8'h00, {5'h00, m[2:0]});
    end
    done("mode_codes");
    // a bad code must not leak through, not even its low bits
    for (int c = 5; c <= 7; c++) begin
      wr(8'h00, {13'h0, c[2:0]}, 1);
      check_mode(3'h4);
    end
    rd(8'h00, 8'h04);
    done("invalid_codes");
    foreach (pat[i]) begin
      wr(8'h01, {8'h00, pat[i]}, 1);
      check_lamp(pat[i]);
      rd(8'h01, pat[i]);
    end
    check_mode(3'h4);
    done("lamp_bits");
    // two bytes in one frame step the pointer from mode to lamp setup
    wr(8'h00, 16'h5a02, 2);
    check_mode(3'h2);
    check_lamp(8'h5a);
    wr(8'h05, 16'hffff, 2);
    wr(8'h01, 16'hff3c, 2);
    rd(8'h05, 8'h00);
    rd(8'h01, 8'h3c);
    check_mode(3'h2);
    done("pointer_and_reserved");
    tcmr_host_model_inst.reg_write(DEV ^ 7'h01, 8'h00, 16'h0003, 1);
    `CHK(tcmr_host_model_inst.all_acked, 1'b0)
    check_mode(3'h2);
    done("other_address");
    tcmr_host_model_inst.q_cycles = 20;
    wr(8'h00, 16'h0001, 1);
    rd(8'h00, 8'h01);
    tcmr_host_model_inst.q_cycles = 6;
    done("slow_host");
    // a reset in mid-run brings back the power-on values
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check_mode(3'h0);
    check_lamp(8'h00);
    rd(8'h01, 8'h00);
    done("second_reset");
    final_report();
  end

  // the run needs about 44k cycles; this only ends a hang
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t: run did not finish in time", $time);
    final_report();
  end
endmodule // tcmr_regs_bench
